/* core/scg_gate_cell.sv */
// Clock gate enable for one bus group: pass in run mode, pass while enabled in sleep.
`timescale 1ns/1ps
module scg_gate_cell #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         sleep,
   input  wire logic [W-1:0] slp_en,
   output logic      [W-1:0] clk_on
);
   logic [W-1:0] on_reg;
   logic [W-1:0] on_next;

   // Per-bit gate enable, registered so the gate sees a glitch-free level.
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_comb begin
            on_next[i] = !sleep || slp_en[i];
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         on_reg <= '1;
      end else begin
         on_reg <= on_next;
      end
   end

   assign clk_on = on_reg;
endmodule

/* core/scg_top.sv */
// Sleep-mode clock gating, interrupt pending bits and status flags of the reset and clock controller.
// Operation
// R1: five separate sleep enables, second high-speed bus
// R2: one sleep enable for external memory controller
// R3: independent sleep enables, low-speed peripheral bus
// R4: independent sleep enables, high-speed peripheral bus
// R5: sleep stops clocks whose enable is clear
// R6: wakeup restores gated clocks without software
// R7: all sleep enables set after reset
// R8: six individual ready interrupt enables
// R9: readable ready flags for oscillators and PLLs
// R10: latch readable reset-cause flags
// R11: one command clears all reset flags
// R12: readable pending bit per interrupt source
// R13: clear selected pending bits by command
// R14: clock security event pending, readable, clearable
// R15: ready pending sets on enabled ready rise
// R16: reset flags change only on cause or clear
`timescale 1ns/1ps
module scg_top (
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire logic [scg_pkg::ADDR_W-1:0]   addr,
   input  wire logic [scg_pkg::DATA_W-1:0]   wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [scg_pkg::DATA_W-1:0]   rdata,
   input  wire logic                         sleep,
   input  wire logic [scg_pkg::RDY_W-1:0]    osc_ready,
   input  wire logic                         clock_security_event,
   input  wire logic [scg_pkg::RST_W-1:0]    reset_cause,
   output scg_pkg::scg_gate_s                clk_on,
   output logic                              irq
);
   scg_pkg::scg_gate_s                bus;
   scg_pkg::scg_gate_s                slp_reg, slp_next;
   logic [scg_pkg::RDY_W-1:0]         ien_reg, ien_next;
   logic [scg_pkg::PEND_W-1:0]        pend_reg, pend_next;
   logic [scg_pkg::RST_W-1:0]         rflag_reg, rflag_next;
   logic [scg_pkg::DATA_W-1:0]        rdata_reg, rdata_next;
   logic [scg_pkg::RDY_W-1:0]         rdy_s1_reg, rdy_s2_reg, rdy_d_reg;
   logic                              css_s1_reg, css_s2_reg, css_d_reg;
   logic [scg_pkg::RST_W-1:0]         rc_s1_reg, rc_s2_reg;
   logic                              slp_s1_reg, slp_s2_reg;
   logic [scg_pkg::PEND_W-1:0]        pend_set;
   logic [scg_pkg::PEND_W-1:0]        pend_clr;

   function automatic logic hit(input logic [scg_pkg::ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   always_comb begin
      bus.hs2 = wdata[scg_pkg::HS2_W-1:0];
      bus.hs3 = wdata[scg_pkg::HS3_W-1:0];
      bus.ls1 = wdata[scg_pkg::LS1_W-1:0];
      bus.ls2 = wdata[scg_pkg::LS2_W-1:0];
   end

   // Pins from other domains pass two flip-flops before use.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdy_s1_reg <= '0;
         rdy_s2_reg <= '0;
         rdy_d_reg  <= '0;
         css_s1_reg <= 1'b0;
         css_s2_reg <= 1'b0;
         css_d_reg  <= 1'b0;
         rc_s1_reg  <= '0;
         rc_s2_reg  <= '0;
         slp_s1_reg <= 1'b0;
         slp_s2_reg <= 1'b0;
      end else begin
         rdy_s1_reg <= osc_ready;
         rdy_s2_reg <= rdy_s1_reg;
         rdy_d_reg  <= rdy_s2_reg;
         css_s1_reg <= clock_security_event;
         css_s2_reg <= css_s1_reg;
         css_d_reg  <= css_s2_reg;
         rc_s1_reg  <= reset_cause;
         rc_s2_reg  <= rc_s1_reg;
         slp_s1_reg <= sleep;
         slp_s2_reg <= slp_s1_reg;
      end
   end

   // Register writes, pending and reset flag updates.
   always_comb begin
      slp_next   = slp_reg;
      ien_next   = ien_reg;
      rflag_next = rflag_reg | rc_s2_reg; // R10 R16
      pend_set   = '0;
      pend_clr   = '0;
      pend_set[scg_pkg::RDY_W-1:0] = rdy_s2_reg & ~rdy_d_reg & ien_reg; // R15
      pend_set[scg_pkg::PEND_CSS_BIT] = css_s2_reg & ~css_d_reg; // R14
      if (wr) begin
         if (hit(addr, scg_pkg::OFF_SLP_HS2)) begin
            slp_next.hs2 = bus.hs2; // R1
         end else if (hit(addr, scg_pkg::OFF_SLP_HS3)) begin
            slp_next.hs3 = bus.hs3; // R2
         end else if (hit(addr, scg_pkg::OFF_SLP_LS1)) begin
            slp_next.ls1 = bus.ls1; // R3
         end else if (hit(addr, scg_pkg::OFF_SLP_LS2)) begin
            slp_next.ls2 = bus.ls2; // R4
         end else if (hit(addr, scg_pkg::OFF_IRQ_EN)) begin
            ien_next = wdata[scg_pkg::RDY_W-1:0]; // R8
         end else if (hit(addr, scg_pkg::OFF_IRQ_PEND)) begin
            pend_clr = wdata[scg_pkg::PEND_W-1:0]; // R13
         end else if (hit(addr, scg_pkg::OFF_RST_CLR)) begin
            if (wdata[scg_pkg::RST_CLR_BIT]) begin
               rflag_next = rc_s2_reg; // R11
            end
         end
      end
      // A set in the same cycle as its clear wins.
      pend_next = (pend_reg & ~pend_clr) | pend_set; // R13
      pend_next[scg_pkg::PEND_RSV_BIT] = 1'b0;
   end

   // Read path: data stand in the cycle after the strobe only.
   always_comb begin
      rdata_next = '0;
      if (rd) begin
         if (hit(addr, scg_pkg::OFF_SLP_HS2)) begin
            rdata_next[scg_pkg::HS2_W-1:0] = slp_reg.hs2;
         end else if (hit(addr, scg_pkg::OFF_SLP_HS3)) begin
            rdata_next[scg_pkg::HS3_W-1:0] = slp_reg.hs3;
         end else if (hit(addr, scg_pkg::OFF_SLP_LS1)) begin
            rdata_next[scg_pkg::LS1_W-1:0] = slp_reg.ls1;
         end else if (hit(addr, scg_pkg::OFF_SLP_LS2)) begin
            rdata_next[scg_pkg::LS2_W-1:0] = slp_reg.ls2;
         end else if (hit(addr, scg_pkg::OFF_IRQ_EN)) begin
            rdata_next[scg_pkg::RDY_W-1:0] = ien_reg;
         end else if (hit(addr, scg_pkg::OFF_IRQ_PEND)) begin
            rdata_next[scg_pkg::PEND_W-1:0] = pend_reg; // R12
         end else if (hit(addr, scg_pkg::OFF_READY)) begin
            rdata_next[scg_pkg::RDY_W-1:0] = rdy_s2_reg; // R9
         end else if (hit(addr, scg_pkg::OFF_RST_FLAG)) begin
            rdata_next[scg_pkg::RST_W-1:0] = rflag_reg; // R10
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slp_reg.hs2 <= scg_pkg::HS2_RST; // R7
         slp_reg.hs3 <= scg_pkg::HS3_RST; // R7
         slp_reg.ls1 <= scg_pkg::LS1_RST; // R7
         slp_reg.ls2 <= scg_pkg::LS2_RST; // R7
         ien_reg     <= '0;
         pend_reg    <= '0;
         rflag_reg   <= '0;
         rdata_reg   <= '0;
      end else begin
         slp_reg     <= slp_next;
         ien_reg     <= ien_next;
         pend_reg    <= pend_next;
         rflag_reg   <= rflag_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign irq   = |pend_reg;

   // Gate enables per bus group; leaving sleep reopens every gate by itself.
   scg_gate_cell #(.W(scg_pkg::HS2_W)) u_hs2 (
      .clk    (clk),
      .nrst   (nrst),
      .sleep  (slp_s2_reg),
      .slp_en (slp_reg.hs2),
      .clk_on (clk_on.hs2)
   ); // R5 R6
   scg_gate_cell #(.W(scg_pkg::HS3_W)) u_hs3 (
      .clk    (clk),
      .nrst   (nrst),
      .sleep  (slp_s2_reg),
      .slp_en (slp_reg.hs3),
      .clk_on (clk_on.hs3)
   );
   scg_gate_cell #(.W(scg_pkg::LS1_W)) u_ls1 (
      .clk    (clk),
      .nrst   (nrst),
      .sleep  (slp_s2_reg),
      .slp_en (slp_reg.ls1),
      .clk_on (clk_on.ls1)
   );
   scg_gate_cell #(.W(scg_pkg::LS2_W)) u_ls2 (
      .clk    (clk),
      .nrst   (nrst),
      .sleep  (slp_s2_reg),
      .slp_en (slp_reg.ls2),
      .clk_on (clk_on.ls2)
   );

   a_sleep_gate_off: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && !slp_reg.ls1[0]) |=> !clk_on.ls1[0])
      else $error("clock not gated in sleep");
   a_wake_restore: assert property (@(posedge clk) disable iff (!nrst) // R6
      !slp_s2_reg |=> clk_on == '1)
      else $error("clock not restored on wakeup");
   a_pend_ready_set: assert property (@(posedge clk) disable iff (!nrst) // R15
      (rdy_s2_reg[0] && !rdy_d_reg[0] && ien_reg[0]) |=> pend_reg[0])
      else $error("ready pending not set");
   a_pend_css_set: assert property (@(posedge clk) disable iff (!nrst) // R14
      (css_s2_reg && !css_d_reg) |=> pend_reg[scg_pkg::PEND_CSS_BIT])
      else $error("security pending not set");
   a_pend_clear: assert property (@(posedge clk) disable iff (!nrst) // R13
      (wr && hit(addr, scg_pkg::OFF_IRQ_PEND) && wdata[1] && !pend_set[1]) |=> !pend_reg[1])
      else $error("pending bit not cleared");
   a_pend_hold: assert property (@(posedge clk) disable iff (!nrst) // R15
      (pend_reg[2] && !(wr && hit(addr, scg_pkg::OFF_IRQ_PEND))) |=> pend_reg[2])
      else $error("pending bit lost");
   a_rst_flag_clear: assert property (@(posedge clk) disable iff (!nrst) // R11
      (wr && hit(addr, scg_pkg::OFF_RST_CLR) && wdata[0] && rc_s2_reg == '0) |=> rflag_reg == '0)
      else $error("reset flags not cleared");
   a_rst_flag_keep: assert property (@(posedge clk) disable iff (!nrst) // R16
      !(wr && hit(addr, scg_pkg::OFF_RST_CLR) && wdata[scg_pkg::RST_CLR_BIT])
      |=> (rflag_reg & $past(rflag_reg)) == $past(rflag_reg))
      else $error("reset flag changed without cause");
   a_ready_read: assert property (@(posedge clk) disable iff (!nrst) // R9
      (rd && hit(addr, scg_pkg::OFF_READY)) |=> rdata[scg_pkg::RDY_W-1:0] == $past(rdy_s2_reg))
      else $error("ready flags misread");
   a_irq_level: assert property (@(posedge clk) disable iff (!nrst) // R12
      (pend_reg != '0) |-> irq)
      else $error("irq not raised");
   a_en_write: assert property (@(posedge clk) disable iff (!nrst) // R8
      (wr && hit(addr, scg_pkg::OFF_IRQ_EN)) |=> ien_reg == $past(wdata[scg_pkg::RDY_W-1:0]))
      else $error("interrupt enable not written");
   a_slp_write: assert property (@(posedge clk) disable iff (!nrst) // R1
      (wr && hit(addr, scg_pkg::OFF_SLP_HS2)) |=> slp_reg.hs2 == $past(wdata[scg_pkg::HS2_W-1:0]))
      else $error("sleep enable not written");

   // Gate enables follow the sleep enables of every bus group.
   a_hs2_gate_off: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && !slp_reg.hs2[1]) |=> !clk_on.hs2[1])
      else $error("high-speed clock not gated in sleep");
   a_hs3_gate_off: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && !slp_reg.hs3[0]) |=> !clk_on.hs3[0])
      else $error("memory controller clock not gated in sleep");
   a_ls2_gate_off: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && !slp_reg.ls2[4]) |=> !clk_on.ls2[4])
      else $error("peripheral clock not gated in sleep");
   a_hs2_keep_on: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && slp_reg.hs2[0]) |=> clk_on.hs2[0])
      else $error("enabled clock stopped in sleep");
   a_ls1_keep_on: assert property (@(posedge clk) disable iff (!nrst) // R5
      (slp_s2_reg && slp_reg.ls1[1]) |=> clk_on.ls1[1])
      else $error("enabled clock stopped in sleep");

   // Sleep and interrupt enable writes land and then hold.
   a_hs3_write: assert property (@(posedge clk) disable iff (!nrst) // R2
      (wr && hit(addr, scg_pkg::OFF_SLP_HS3)) |=> slp_reg.hs3 == $past(wdata[scg_pkg::HS3_W-1:0]))
      else $error("memory controller sleep enable not written");
   a_ls1_write: assert property (@(posedge clk) disable iff (!nrst) // R3
      (wr && hit(addr, scg_pkg::OFF_SLP_LS1)) |=> slp_reg.ls1 == $past(wdata[scg_pkg::LS1_W-1:0]))
      else $error("low-speed sleep enable not written");
   a_ls2_write: assert property (@(posedge clk) disable iff (!nrst) // R4
      (wr && hit(addr, scg_pkg::OFF_SLP_LS2)) |=> slp_reg.ls2 == $past(wdata[scg_pkg::LS2_W-1:0]))
      else $error("high-speed bus sleep enable not written");
   a_slp_keep: assert property (@(posedge clk) disable iff (!nrst) // R7
      !wr |=> slp_reg == $past(slp_reg))
      else $error("sleep enable changed without write");
   a_ien_keep: assert property (@(posedge clk) disable iff (!nrst) // R8
      !(wr && hit(addr, scg_pkg::OFF_IRQ_EN)) |=> ien_reg == $past(ien_reg))
      else $error("interrupt enable changed without write");

   // Read data carry the addressed register for one cycle only.
   a_slp_read: assert property (@(posedge clk) disable iff (!nrst) // R1
      (rd && hit(addr, scg_pkg::OFF_SLP_HS2)) |=> rdata[scg_pkg::HS2_W-1:0] == $past(slp_reg.hs2))
      else $error("sleep enable misread");
   a_en_read: assert property (@(posedge clk) disable iff (!nrst) // R8
      (rd && hit(addr, scg_pkg::OFF_IRQ_EN)) |=> rdata[scg_pkg::RDY_W-1:0] == $past(ien_reg))
      else $error("interrupt enable misread");
   a_pend_read: assert property (@(posedge clk) disable iff (!nrst) // R12
      (rd && hit(addr, scg_pkg::OFF_IRQ_PEND)) |=> rdata[scg_pkg::PEND_W-1:0] == $past(pend_reg))
      else $error("pending bits misread");
   a_flag_read: assert property (@(posedge clk) disable iff (!nrst) // R10
      (rd && hit(addr, scg_pkg::OFF_RST_FLAG)) |=> rdata[scg_pkg::RST_W-1:0] == $past(rflag_reg))
      else $error("reset flags misread");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst) // R9
      !rd |=> rdata == '0)
      else $error("read data outside read cycle");

   // Pending bits and reset flags move only for their causes.
   a_pend_rise_cause: assert property (@(posedge clk) disable iff (!nrst) // R15
      (pend_reg & ~$past(pend_reg) & ~$past(pend_set)) == '0)
      else $error("pending bit set without event");
   a_pend_masked_src: assert property (@(posedge clk) disable iff (!nrst) // R15
      (rdy_s2_reg[1] && !rdy_d_reg[1] && !ien_reg[1] && !pend_reg[1]) |=> !pend_reg[1])
      else $error("disabled ready event pended");
   a_css_clear: assert property (@(posedge clk) disable iff (!nrst) // R14
      (wr && hit(addr, scg_pkg::OFF_IRQ_PEND) && wdata[scg_pkg::PEND_CSS_BIT]
      && !pend_set[scg_pkg::PEND_CSS_BIT]) |=> !pend_reg[scg_pkg::PEND_CSS_BIT])
      else $error("security pending not cleared");
   a_pend_rsv_zero: assert property (@(posedge clk) disable iff (!nrst) // R12
      pend_reg[scg_pkg::PEND_RSV_BIT] == 1'b0)
      else $error("reserved pending bit set");
   a_irq_idle: assert property (@(posedge clk) disable iff (!nrst) // R12
      (pend_reg == '0) |-> !irq)
      else $error("irq raised with nothing pending");
   a_rst_flag_rise: assert property (@(posedge clk) disable iff (!nrst) // R16
      (rflag_reg & ~$past(rflag_reg) & ~$past(rc_s2_reg)) == '0)
      else $error("reset flag set without cause");
   a_rst_flag_cause: assert property (@(posedge clk) disable iff (!nrst) // R10
      (rc_s2_reg != '0) |=> (rflag_reg & $past(rc_s2_reg)) == $past(rc_s2_reg))
      else $error("reset cause not latched");
endmodule

/* dv/scg_top_tb_top.sv */
// Self-checking testbench of the sleep clock gating, pending and flag block.
`timescale 1ns/1ps
module scg_top_tb_top;
   logic        clk;
   logic        nrst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        sleep;
   logic [5:0]  osc_ready;
   logic        clock_security_event;
   logic [6:0]  reset_cause;
   logic        irq;
   int          err_total;
   int          n_compared;
   int          cyc;
   scg_pkg::scg_gate_s clk_on;

   scg_top dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sleep(sleep), .osc_ready(osc_ready), .clock_security_event(clock_security_event),
      .reset_cause(reset_cause), .clk_on(clk_on), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk({32'h0, rdata}, {32'h0, exp});
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Every sleep enable reads back set and every clock runs after reset.
   task automatic t_reset_values();
      rd_chk(scg_pkg::OFF_SLP_HS2, 32'h0000001F);
      rd_chk(scg_pkg::OFF_SLP_HS3, 32'h00000001);
      rd_chk(scg_pkg::OFF_SLP_LS1, 32'h007FFFFF);
      rd_chk(scg_pkg::OFF_SLP_LS2, 32'h00001FFF);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
      chk({63'h0, irq}, 64'h0);
   endtask

   // Cleared enables stop their clocks only while asleep; wakeup restores all.
   task automatic t_sleep_gating();
      wr_reg(scg_pkg::OFF_SLP_HS2, 32'h00000015);
      wr_reg(scg_pkg::OFF_SLP_HS3, 32'h00000000);
      wr_reg(scg_pkg::OFF_SLP_LS1, 32'h002AAAAA);
      wr_reg(scg_pkg::OFF_SLP_LS2, 32'h00000F0F);
      rd_chk(scg_pkg::OFF_SLP_LS1, 32'h002AAAAA);
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
      @(posedge clk);
      sleep <= 1'b1;
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 5'h15, 1'h0, 23'h2AAAAA, 13'h0F0F});
      @(posedge clk);
      sleep <= 1'b0;
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
   endtask

   // Enabled ready rises set pending bits, cleared per selected bit.
   task automatic t_ready_pending();
      wr_reg(scg_pkg::OFF_IRQ_EN, 32'h0000003F);
      rd_chk(scg_pkg::OFF_IRQ_EN, 32'h0000003F);
      @(posedge clk);
      osc_ready <= 6'h3F;
      wait_cyc(5);
      rd_chk(scg_pkg::OFF_READY, 32'h0000003F);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h0000003F);
      chk({63'h0, irq}, 64'h1);
      wr_reg(scg_pkg::OFF_IRQ_PEND, 32'h00000005);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h0000003A);
      wr_reg(scg_pkg::OFF_IRQ_PEND, 32'h0000003A);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h00000000);
      chk({63'h0, irq}, 64'h0);
      @(posedge clk);
      osc_ready <= 6'h00;
      wr_reg(scg_pkg::OFF_IRQ_EN, 32'h00000001);
      wait_cyc(4);
      @(posedge clk);
      osc_ready <= 6'h03;
      wait_cyc(5);
      rd_chk(scg_pkg::OFF_READY, 32'h00000003);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h00000001);
      wr_reg(scg_pkg::OFF_IRQ_PEND, 32'h00000001);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h00000000);
   endtask

   // A security event pends on bit 7 and clears like the others.
   task automatic t_security();
      @(posedge clk);
      clock_security_event <= 1'b1;
      wait_cyc(3);
      @(posedge clk);
      clock_security_event <= 1'b0;
      wait_cyc(4);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h00000080);
      chk({63'h0, irq}, 64'h1);
      wr_reg(scg_pkg::OFF_IRQ_PEND, 32'h00000080);
      rd_chk(scg_pkg::OFF_IRQ_PEND, 32'h00000000);
   endtask

   // Causes latch and accumulate, survive a read-only write, clear together.
   task automatic t_reset_flags();
      @(posedge clk);
      reset_cause <= 7'h55;
      wait_cyc(5);
      @(posedge clk);
      reset_cause <= 7'h00;
      wait_cyc(4);
      rd_chk(scg_pkg::OFF_RST_FLAG, 32'h00000055);
      @(posedge clk);
      reset_cause <= 7'h02;
      wait_cyc(5);
      @(posedge clk);
      reset_cause <= 7'h00;
      wr_reg(scg_pkg::OFF_RST_FLAG, 32'h00000000);
      wait_cyc(4);
      rd_chk(scg_pkg::OFF_RST_FLAG, 32'h00000057);
      wr_reg(scg_pkg::OFF_RST_CLR, 32'h00000001);
      rd_chk(scg_pkg::OFF_RST_FLAG, 32'h00000000);
      wr_reg(8'h40, 32'hFFFFFFFF);
      rd_chk(8'h40, 32'h00000000);
   endtask

   // A reset in mid-run reopens gated clocks and sets every sleep enable again.
   task automatic t_mid_reset();
      wr_reg(scg_pkg::OFF_SLP_HS2, 32'h00000000);
      @(posedge clk);
      sleep <= 1'b1;
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 5'h00, 1'h0, 23'h2AAAAA, 13'h0F0F});
      @(posedge clk);
      nrst <= 1'b0;
      wait_cyc(2);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
      @(posedge clk);
      nrst <= 1'b1;
      rd_chk(scg_pkg::OFF_SLP_HS2, 32'h0000001F);
      rd_chk(scg_pkg::OFF_SLP_LS1, 32'h007FFFFF);
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
      @(posedge clk);
      sleep <= 1'b0;
      wait_cyc(4);
      chk({22'h0, clk_on}, {22'h0, 42'h3FFFFFFFFFF});
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         $display("unexpected at %0t: run did not finish in time", $time);
         complete_run();
      end
   end

   initial begin
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      nrst = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      sleep = 1'b0;
      osc_ready = 6'h00;
      clock_security_event = 1'b0;
      reset_cause = 7'h00;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset_values();
      t_sleep_gating();
      t_ready_pending();
      t_security();
      t_reset_flags();
      t_mid_reset();
      complete_run();
   end
endmodule

/* inc/scg_pkg.sv */
// Package with register map, field layouts and carriers of the sleep clock gating block.
package scg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets.
   localparam logic [7:0] OFF_SLP_HS2  = 8'h00;
   localparam logic [7:0] OFF_SLP_HS3  = 8'h04;
   localparam logic [7:0] OFF_SLP_LS1  = 8'h08;
   localparam logic [7:0] OFF_SLP_LS2  = 8'h0C;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
   localparam logic [7:0] OFF_IRQ_PEND = 8'h14;
   localparam logic [7:0] OFF_READY    = 8'h18;
   localparam logic [7:0] OFF_RST_FLAG = 8'h1C;
   localparam logic [7:0] OFF_RST_CLR  = 8'h20;

   // Field widths.
   localparam int HS2_W  = 5;
   localparam int HS3_W  = 1;
   localparam int LS1_W  = 23;
   localparam int LS2_W  = 13;
   localparam int RDY_W  = 6;
   localparam int PEND_W = 8;
   localparam int RST_W  = 7;

   // Pending and reset-clear bit positions; pending bit 6 is reserved and reads zero.
   localparam int PEND_CSS_BIT = 7;
   localparam int PEND_RSV_BIT = 6;
   localparam int RST_CLR_BIT  = 0;

   // Reset values: every sleep enable set after reset.
   localparam logic [HS2_W-1:0] HS2_RST = 5'h1F;
   localparam logic [HS3_W-1:0] HS3_RST = 1'h1;
   localparam logic [LS1_W-1:0] LS1_RST = 23'h7FFFFF;
   localparam logic [LS2_W-1:0] LS2_RST = 13'h1FFF;

   typedef struct packed {
      logic [HS2_W-1:0] hs2;
      logic [HS3_W-1:0] hs3;
      logic [LS1_W-1:0] ls1;
      logic [LS2_W-1:0] ls2;
   } scg_gate_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } scg_bus_s;
endpackage
